//--- core/rsml_pkg.sv
// Shared constants of the reset supervisor with memory lockout.
package rsml_pkg;

    // Clock rate.
    localparam int unsigned CLK_PERIOD_NS = 8;

    // Reset timeout interval after the supply recovers or a manual reset.
    localparam int unsigned RESET_TIMEOUT_MS = 200;
    localparam int unsigned RESET_TIMEOUT_CYC = RESET_TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;

    // Longest internal non-volatile write cycle (nonvolatile_write_time).
    localparam int unsigned WRITE_CYCLE_MS = 5;
    localparam int unsigned WRITE_CYCLE_CYC = WRITE_CYCLE_MS * 1000000 / CLK_PERIOD_NS;

    // Shortest manual_reset_input pulse that is accepted, rounded up to whole cycles.
    localparam int unsigned MANUAL_GLITCH_NS = 100;
    localparam int unsigned MANUAL_FILT_CYC =
        (MANUAL_GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Supply dips below supply_trip_level shorter than this are ignored.
    localparam int unsigned SUPPLY_GLITCH_NS = 30;
    localparam int unsigned SUPPLY_FILT_CYC =
        (SUPPLY_GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Controller wait after a stable supply (power_on_to_read_delay and write delay).
    localparam int unsigned POWER_ON_TO_ACCESS_MS = 270;

    // Reset values of the filtered inputs and of the pin variant.
    localparam logic SUPPLY_LOW_RESET = 1'b1;
    localparam logic PIN_LEVEL_RESET = 1'b1;
    localparam logic ACTIVE_LOW_DEFAULT = 1'b1;

    // Width of the timeout counters.
    localparam int unsigned TIMER_W = 25;

    // Supervisor states.
    typedef enum logic [1:0] {
        ST_SUPPLY_LOW,
        ST_TIMEOUT,
        ST_RUN
    } rsml_state_t;

endpackage

//--- core/rsml_filter.sv
// Two-flop synchroniser followed by a stable-level glitch filter.
module rsml_filter #(
    parameter int unsigned STABLE = 4,
    parameter logic INIT = 1'b1
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic reset,
    // Raw level in, filtered level out.
    input wire logic raw,
    output logic level
);

    logic s1_q;
    logic s2_q;
    logic dout_q;
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    wire differs = (s2_q != dout_q);
    wire settled = differs && (cnt_q == 8'(STABLE - 1));

    // Only the second flop looks at the first.
    always_ff @(posedge clk) begin
        if (reset) begin
            s1_q <= INIT;
            s2_q <= INIT;
        end else begin
            s1_q <= raw;
            s2_q <= s1_q;
        end
    end

    // A level change shorter than STABLE cycles restarts the count and is lost.
    assign cnt_d = differs ? cnt_q + 8'h01 : 8'h00;

    always_ff @(posedge clk) begin
        if (reset) begin
            cnt_q <= 8'h00;
            dout_q <= INIT;
        end else begin
            cnt_q <= settled ? 8'h00 : cnt_d;
            dout_q <= settled ? s2_q : dout_q;
        end
    end

    assign level = dout_q;

    filt_stable_a: assert property (@(posedge clk) disable iff (reset)
        $changed(dout_q) |-> $past(cnt_q) == 8'(STABLE - 1))
        else $error("Filter output changed before the input was stable.");

endmodule

//--- core/rsml_timer.sv
// Down-counting interval timer that stays busy for exactly COUNT cycles after a load.
module rsml_timer #(
    parameter int unsigned W = 25,
    parameter int unsigned COUNT = 16
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic reset,
    // Start and progress.
    input wire logic load,
    output logic busy,
    output logic done
);

    logic [W-1:0] cnt_q;
    logic busy_q;
    wire last = busy_q && (cnt_q == '0);

    always_ff @(posedge clk) begin
        if (reset) begin
            cnt_q <= '0;
            busy_q <= 1'b0;
        end else if (load) begin
            cnt_q <= W'(COUNT - 1);
            busy_q <= 1'b1;
        end else if (busy_q) begin
            cnt_q <= cnt_q - W'(1);
            busy_q <= !last;
        end
    end

    assign busy = busy_q;
    assign done = last;

endmodule

//--- core/rsml_top.sv
// Supply supervisor with manual reset and serial memory lockout.
// Operation
// - Hold reset while supply is low, then for a further 200 ms timeout.
// - After the timeout stop driving the pin; the pull resistor sets it.
// - Assert reset whenever the supply falls below the trip level.
// - Ignore brief dips of the below-trip indication.
// - A falling edge on the reset pin starts the reset timeout.
// - A manual reset always lasts the full 200 ms, however short the press, once it passes the glitch filter.
// - Manual reset pulses under 100 ns are rejected.
// - While in reset the memory is disabled for reads and writes.
// - Reset aborts a running memory transaction and refuses new ones.
// - Reset blocks new write cycles but never aborts a running one.
// - A write cycle begun before reset runs on to completion.
// - The write cycle starts at a write's stop and lasts 5 ms.
// - During a write cycle release the data line and ignore the address.
// - Reset polarity is a build option; only active low accepts manual reset.
// - A busy write cycle withholds acknowledge; the controller may poll.
module rsml_top #(
    parameter int unsigned RESET_TIMEOUT_CYC = rsml_pkg::RESET_TIMEOUT_CYC,
    parameter int unsigned WRITE_CYCLE_CYC = rsml_pkg::WRITE_CYCLE_CYC,
    parameter int unsigned MANUAL_FILT_CYC = rsml_pkg::MANUAL_FILT_CYC,
    parameter int unsigned SUPPLY_FILT_CYC = rsml_pkg::SUPPLY_FILT_CYC,
    parameter logic ACTIVE_LOW = rsml_pkg::ACTIVE_LOW_DEFAULT
) (
    // Clock and reset.
    input wire logic CLK,
    input wire logic RESET,
    // Supply comparator.
    input wire logic SUPPLY_LOW,
    // Open-drain reset pin.
    input wire logic RST_PIN_LEVEL,
    output logic RST_PIN_DRIVE,
    output logic RST_PIN_OE,
    output logic RST_ACTIVE,
    // Serial memory interface events.
    input wire logic XFER_START,
    input wire logic XFER_STOP,
    input wire logic XFER_WRITE,
    output logic XFER_ACK,
    output logic XFER_ABORT,
    output logic XFER_ACTIVE,
    output logic MEM_ENABLE,
    output logic SDA_RELEASE,
    // Internal write cycle.
    output logic WC_START,
    output logic WC_BUSY
);

    rsml_pkg::rsml_state_t state_q;
    rsml_pkg::rsml_state_t state_d;

    logic low_f;
    logic pin_f;
    logic pin_prev_q;
    logic rst_act_q;
    logic pin_oe_q;
    logic pin_o_q;
    logic xfer_q;
    logic ack_q;
    logic abort_q;
    logic mem_en_q;
    logic sda_rel_q;
    logic wc_start_q;
    logic rst_tmr_busy;
    logic rst_tmr_done;
    logic wc_busy;
    logic wc_done;
    logic [31:0] stay_cnt_q;
    logic [31:0] wc_len_q;

    // Supply indication, filtered so short dips never reach the state machine.
    rsml_filter #(
        .STABLE(SUPPLY_FILT_CYC),
        .INIT(rsml_pkg::SUPPLY_LOW_RESET)
    ) u_supply_filt (
        .clk(CLK),
        .reset(RESET),
        .raw(SUPPLY_LOW),
        .level(low_f)
    );

    // Pin level, filtered so spikes below the glitch limit are never seen.
    rsml_filter #(
        .STABLE(MANUAL_FILT_CYC),
        .INIT(rsml_pkg::PIN_LEVEL_RESET)
    ) u_pin_filt (
        .clk(CLK),
        .reset(RESET),
        .raw(RST_PIN_LEVEL),
        .level(pin_f)
    );

    // A fall is only looked for while the pin is released; our own drive would
    // otherwise retrigger the timeout forever.
    wire manual_fall = ACTIVE_LOW && !pin_oe_q && pin_prev_q && !pin_f;
    wire enter_timeout = (state_q == rsml_pkg::ST_SUPPLY_LOW) && !low_f;
    wire rst_go = (state_d != rsml_pkg::ST_RUN);
    wire rst_load = enter_timeout || ((state_q == rsml_pkg::ST_RUN) && !low_f && manual_fall);

    rsml_timer #(
        .W(rsml_pkg::TIMER_W),
        .COUNT(RESET_TIMEOUT_CYC)
    ) u_rst_tmr (
        .clk(CLK),
        .reset(RESET),
        .load(rst_load),
        .busy(rst_tmr_busy),
        .done(rst_tmr_done)
    );

    always_comb begin
        state_d = state_q;
        case (state_q)
            rsml_pkg::ST_SUPPLY_LOW: begin
                if (!low_f) begin
                    state_d = rsml_pkg::ST_TIMEOUT;
                end
            end
            rsml_pkg::ST_TIMEOUT: begin
                if (low_f) begin
                    state_d = rsml_pkg::ST_SUPPLY_LOW;
                end else if (rst_tmr_done) begin
                    state_d = rsml_pkg::ST_RUN;
                end
            end
            rsml_pkg::ST_RUN: begin
                if (low_f) begin
                    state_d = rsml_pkg::ST_SUPPLY_LOW;
                end else if (manual_fall) begin
                    state_d = rsml_pkg::ST_TIMEOUT;
                end
            end
            default: begin
                state_d = rsml_pkg::ST_SUPPLY_LOW;
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            state_q <= rsml_pkg::ST_SUPPLY_LOW;
            pin_prev_q <= rsml_pkg::PIN_LEVEL_RESET;
        end else begin
            state_q <= state_d;
            pin_prev_q <= pin_f;
        end
    end

    // The pin is only ever pulled to its active level; releasing it leaves the
    // inactive level to the external resistor.
    always_ff @(posedge CLK) begin
        if (RESET) begin
            rst_act_q <= 1'b1;
            pin_oe_q <= 1'b1;
            pin_o_q <= !ACTIVE_LOW;
        end else begin
            rst_act_q <= rst_go;
            pin_oe_q <= rst_go;
            pin_o_q <= !ACTIVE_LOW;
        end
    end

    // Memory side. A start is taken only outside reset and outside a write cycle.
    wire accept = XFER_START && !rst_go && !wc_busy;
    wire abort = xfer_q && rst_go;
    wire wc_go = XFER_STOP && XFER_WRITE && xfer_q && !rst_go && !wc_busy;
    wire xfer_d = abort ? 1'b0 : (accept ? 1'b1 : (XFER_STOP ? 1'b0 : xfer_q));

    // Reset never loads or clears this timer; only power loss can cut a cycle
    // short, and 5 ms of supply headroom are needed for it to finish.
    rsml_timer #(
        .W(rsml_pkg::TIMER_W),
        .COUNT(WRITE_CYCLE_CYC)
    ) u_wc_tmr (
        .clk(CLK),
        .reset(RESET),
        .load(wc_go),
        .busy(wc_busy),
        .done(wc_done)
    );

    always_ff @(posedge CLK) begin
        if (RESET) begin
            xfer_q <= 1'b0;
            ack_q <= 1'b0;
            abort_q <= 1'b0;
            mem_en_q <= 1'b0;
            sda_rel_q <= 1'b1;
            wc_start_q <= 1'b0;
        end else begin
            xfer_q <= xfer_d;
            ack_q <= accept;
            abort_q <= abort;
            mem_en_q <= !rst_go;
            sda_rel_q <= rst_go || wc_go || (wc_busy && !wc_done);
            wc_start_q <= wc_go;
        end
    end

    assign RST_PIN_DRIVE = pin_o_q;
    assign RST_PIN_OE = pin_oe_q;
    assign RST_ACTIVE = rst_act_q;
    assign XFER_ACK = ack_q;
    assign XFER_ABORT = abort_q;
    assign XFER_ACTIVE = xfer_q;
    assign MEM_ENABLE = mem_en_q;
    assign SDA_RELEASE = sda_rel_q;
    assign WC_START = wc_start_q;
    assign WC_BUSY = wc_busy;

    // Checking aids: length of the current timeout and write cycle.
    always_ff @(posedge CLK) begin
        if (RESET) begin
            stay_cnt_q <= 32'h0;
            wc_len_q <= 32'h0;
        end else begin
            stay_cnt_q <= (state_q == rsml_pkg::ST_TIMEOUT) ? stay_cnt_q + 32'h1 : 32'h0;
            wc_len_q <= wc_busy ? wc_len_q + 32'h1 : 32'h0;
        end
    end

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RESET);

    sequence s_enter_reset;
        xfer_q && (state_d != rsml_pkg::ST_RUN);
    endsequence

    sequence s_timeout_ends;
        (state_q == rsml_pkg::ST_TIMEOUT) && (state_d == rsml_pkg::ST_RUN);
    endsequence

    sequence s_wc_running;
        wc_busy && !wc_done;
    endsequence

    supply_low_a: assert property (low_f |=> rst_act_q && RST_PIN_OE)
        else $error("Reset not asserted while the supply is low.");

    timeout_len_a: assert property (
        s_timeout_ends |-> stay_cnt_q == 32'(RESET_TIMEOUT_CYC - 1))
        else $error("Reset timeout did not last the full interval.");

    pin_release_a: assert property (
        $fell(RST_PIN_OE) |-> $past(rst_tmr_done) && !low_f)
        else $error("Reset pin released without an expired timeout.");

    manual_start_a: assert property (
        manual_fall && !low_f |=> rst_act_q ##0 rst_tmr_busy)
        else $error("Manual reset edge did not start the timeout.");

    mem_off_a: assert property (
        rst_act_q |-> !MEM_ENABLE && !XFER_ACK && SDA_RELEASE)
        else $error("Memory enabled during reset.");

    xfer_abort_a: assert property (s_enter_reset |=> XFER_ABORT && !XFER_ACTIVE)
        else $error("Transaction not aborted on reset.");

    no_new_wc_a: assert property ($rose(wc_busy) |-> !rst_act_q && $past(XFER_STOP))
        else $error("Write cycle started in reset or without a stop.");

    wc_keep_a: assert property (s_wc_running |=> wc_busy)
        else $error("Write cycle cut short.");

    wc_len_a: assert property (
        $fell(wc_busy) |-> $past(wc_len_q) == 32'(WRITE_CYCLE_CYC - 1))
        else $error("Write cycle length is wrong.");

    // A start before the last busy cycle is refused, and the line is still released one edge later.
    busy_nack_a: assert property (
        s_wc_running ##0 XFER_START |=> !XFER_ACK && SDA_RELEASE)
        else $error("Address acknowledged during a write cycle.");

    high_variant_a: assert property (!ACTIVE_LOW |-> !manual_fall && RST_PIN_DRIVE)
        else $error("Active-high variant misbehaves.");

    wc_release_a: assert property (
        wc_busy |-> SDA_RELEASE)
        else $error("Data line not released during a write cycle.");

    wc_start_a: assert property (
        WC_START |-> WC_BUSY && !RST_ACTIVE)
        else $error("Write cycle started in reset or without busy.");

    abort_reset_a: assert property (
        XFER_ABORT |-> RST_ACTIVE)
        else $error("Transaction aborted outside reset.");

    ack_run_a: assert property (
        XFER_ACK |-> MEM_ENABLE)
        else $error("Start accepted while the memory is disabled.");

    reset_closed_a: assert property (
        RST_ACTIVE |-> !XFER_ACTIVE)
        else $error("Transaction open during reset.");

    run_supply_a: assert property (
        !RST_ACTIVE |-> !$past(low_f))
        else $error("Reset released while the supply was low.");

    timeout_timer_a: assert property (
        (state_q == rsml_pkg::ST_TIMEOUT) |-> rst_tmr_busy)
        else $error("Timeout state without a running timer.");

endmodule

//--- test/rsml_host_model.sv
// Controller-side model: pull-up on the reset line and a push button.
module rsml_host_model (
    // Reset pin as driven by the supervisor.
    input wire logic rst_pin_drive,
    input wire logic rst_pin_oe,
    // Push button, pulls the line low while pressed.
    input wire logic push_low,
    // Resolved line level and access permission.
    output logic pin_level,
    output logic access_ok
);
    timeunit 1ns;
    timeprecision 1ps;
    // Open drain: the line only goes low when someone pulls it, else the pull-up wins.
    assign pin_level = !((rst_pin_oe && !rst_pin_drive) || push_low);
    // The controller starts memory traffic only once reset has gone idle.
    assign access_ok = pin_level;
endmodule

//--- test/rsml_top_test.sv
// Self-checking testbench of the reset supervisor with memory lockout.
`define CHECK(got, exp) begin \
    num_checks++; \
    if ((got) !== (exp)) begin \
        mismatches++; \
        $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
    end \
end
module rsml_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    // Short counts keep the run brief; expectations derive from them.
    localparam int unsigned TMO = 50;
    localparam int unsigned WCC = 30;
    int mismatches = 0;
    int num_checks = 0;
    logic clk, reset, supply_low, push_low, xs, xp, xw;
    logic pin_o, pin_oe, pin_level, access_ok, rst_active;
    logic ack, abort, active, mem_en, sda_rel, wc_start, wc_busy;
    rsml_top #(.RESET_TIMEOUT_CYC(TMO), .WRITE_CYCLE_CYC(WCC)) dut_u (
        .CLK(clk), .RESET(reset), .SUPPLY_LOW(supply_low), .RST_PIN_LEVEL(pin_level),
        .RST_PIN_DRIVE(pin_o), .RST_PIN_OE(pin_oe), .RST_ACTIVE(rst_active),
        .XFER_START(xs), .XFER_STOP(xp), .XFER_WRITE(xw), .XFER_ACK(ack),
        .XFER_ABORT(abort), .XFER_ACTIVE(active), .MEM_ENABLE(mem_en),
        .SDA_RELEASE(sda_rel), .WC_START(wc_start), .WC_BUSY(wc_busy)
    );
    rsml_host_model host_u (
        .rst_pin_drive(pin_o), .rst_pin_oe(pin_oe), .push_low(push_low),
        .pin_level(pin_level), .access_ok(access_ok)
    );
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic wait_rst(input logic v, input int lim, output int n);
        n = 0;
        while (rst_active !== v && n < lim) begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask
    task automatic start_req(output logic a);
        @(posedge clk) xs <= 1'b1;
        @(posedge clk) xs <= 1'b0;
        #1 a = ack;
    endtask
    task automatic stop_req(input logic wr, output logic w);
        @(posedge clk) begin
            xp <= 1'b1;
            xw <= wr;
        end
        @(posedge clk) begin
            xp <= 1'b0;
            xw <= 1'b0;
        end
        #1 w = wc_start;
    endtask
    task automatic recover();
        int n;
        @(posedge clk) supply_low <= 1'b0;
        wait_rst(1'b0, 80, n);
        `CHECK(n < 80, 1'b1)
        repeat (20) @(posedge clk);
    endtask
    task automatic power_up();
        int n;
        repeat (10) @(posedge clk);
        #1;
        `CHECK({rst_active, pin_oe, pin_o, mem_en}, 4'hc)
        @(posedge clk) supply_low <= 1'b0;
        repeat (TMO - 5) @(posedge clk);
        #1;
        `CHECK(rst_active, 1'b1)
        wait_rst(1'b0, 30, n);
        `CHECK(n < 30, 1'b1)
        `CHECK({pin_oe, pin_level, mem_en}, 3'h3)
    endtask
    task automatic supply_dips();
        int n;
        @(posedge clk) supply_low <= 1'b1;
        repeat (2) @(posedge clk);
        supply_low <= 1'b0;
        wait_rst(1'b1, 15, n);
        `CHECK(n, 15)
        @(posedge clk) supply_low <= 1'b1;
        wait_rst(1'b1, 12, n);
        `CHECK(n < 12, 1'b1)
        recover();
    endtask
    task automatic manual_reset();
        int n;
        // A 40 ns press is a glitch and must leave the line idle.
        @(posedge clk) push_low <= 1'b1;
        repeat (5) @(posedge clk);
        push_low <= 1'b0;
        wait_rst(1'b1, 25, n);
        `CHECK(n, 25)
        @(posedge clk) push_low <= 1'b1;
        wait_rst(1'b1, 25, n);
        `CHECK(n < 25, 1'b1)
        @(posedge clk) push_low <= 1'b0;
        wait_rst(1'b0, 80, n);
        `CHECK(n >= TMO - 5 && n < 80, 1'b1)
        repeat (20) @(posedge clk);
    endtask
    task automatic mem_write();
        logic a, w;
        int n;
        `CHECK(access_ok, 1'b1)
        start_req(a);
        `CHECK({a, active}, 2'h3)
        stop_req(1'b1, w);
        `CHECK({w, wc_busy, active}, 3'h6)
        `CHECK(sda_rel, 1'b1)
        start_req(a);
        `CHECK(a, 1'b0)
        n = 2;
        while (wc_busy === 1'b1 && n < 100) begin
            @(posedge clk);
            #1;
            n++;
        end
        `CHECK(n, WCC)
        `CHECK(sda_rel, 1'b0)
        start_req(a);
        `CHECK(a, 1'b1)
        stop_req(1'b0, w);
        `CHECK(w, 1'b0)
    endtask
    task automatic abort_in_reset();
        logic a, w, ab;
        start_req(a);
        `CHECK(a, 1'b1)
        @(posedge clk) supply_low <= 1'b1;
        ab = 1'b0;
        repeat (14) begin
            @(posedge clk);
            #1;
            ab |= abort;
        end
        `CHECK({ab, active, mem_en}, 3'h4)
        start_req(a);
        `CHECK(a, 1'b0)
        stop_req(1'b1, w);
        `CHECK(w, 1'b0)
        recover();
    endtask
    task automatic write_through_reset();
        logic a, w;
        int n;
        start_req(a);
        stop_req(1'b1, w);
        `CHECK(w, 1'b1)
        @(posedge clk) supply_low <= 1'b1;
        #1 n = 1;
        while (wc_busy === 1'b1 && n < 100) begin
            @(posedge clk);
            #1;
            n++;
        end
        `CHECK(n, WCC)
        `CHECK(rst_active, 1'b1)
        recover();
    endtask
    initial begin
        reset = 1'b1;
        supply_low = 1'b1;
        push_low = 1'b0;
        xs = 1'b0;
        xp = 1'b0;
        xw = 1'b0;
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        power_up();
        supply_dips();
        manual_reset();
        mem_write();
        abort_in_reset();
        write_through_reset();
        results();
    end
    // The tests need about 550 cycles; a hang is cut off well beyond that.
    initial begin
        #100000;
        mismatches++;
        results();
    end
endmodule
